// file: hw/osmc_pkg.sv
// Constants, register map and encodings of the optical sensor measurement control block.
// Assumes a single 20 MHz clock domain and a byte-wide host register port.
package osmc_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int unsigned OSMC_CLK_HZ = 20_000_000;
  localparam int unsigned OSMC_CLK_PERIOD_NS = 50;
  localparam logic [3:0] OSMC_SOFT_RESET_CYCLES = 4'h4;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] OSMC_ADDR_OPERATING_MODE_CONTROL = 8'h09;
  localparam logic [7:0] OSMC_ADDR_ACQUISITION_CONFIG = 8'h0a;
  localparam logic [7:0] OSMC_ADDR_RED_LED_AMPLITUDE = 8'h0c;
  localparam logic [7:0] OSMC_ADDR_IR_LED_AMPLITUDE = 8'h0d;
  localparam logic [7:0] OSMC_ADDR_SLOT_SELECT_LOW = 8'h11;
  localparam logic [7:0] OSMC_ADDR_SLOT_SELECT_HIGH = 8'h12;
  localparam logic [7:0] OSMC_ADDR_DIE_TEMP_WHOLE = 8'h1f;
  localparam logic [7:0] OSMC_ADDR_DIE_TEMP_FRACTION = 8'h20;
  localparam logic [7:0] OSMC_ADDR_DIE_TEMP_TRIGGER = 8'h21;
  localparam logic [7:0] OSMC_REG_RESET = 8'h00;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int OSMC_MODE_POWER_SAVE_REQUEST_BIT = 7;
  localparam int OSMC_MODE_RESET_BIT = 6;
  localparam int OSMC_MODE_LSB = 0;
  localparam int OSMC_CFG_RANGE_LSB = 5;
  localparam int OSMC_CFG_RATE_LSB = 2;
  localparam int OSMC_CFG_PW_LSB = 0;
  localparam int OSMC_SLOT_LO_LSB = 0;
  localparam int OSMC_SLOT_HI_LSB = 4;
  localparam int OSMC_TEMP_EN_BIT = 0;

  // ****************************************
  // Mode and slot encodings
  // ****************************************
  localparam logic [2:0] OSMC_MODE_HEART_RATE = 3'h2;
  localparam logic [2:0] OSMC_MODE_OXIMETRY = 3'h3;
  localparam logic [2:0] OSMC_MODE_MULTI_LED = 3'h7;
  localparam logic [2:0] OSMC_SLOT_OFF = 3'h0;
  localparam logic [2:0] OSMC_SLOT_RED = 3'h1;
  localparam logic [2:0] OSMC_SLOT_IR = 3'h2;
  localparam logic [2:0] OSMC_SLOT_LAST_ACTIVE = 3'h4;
  localparam logic [1:0] OSMC_LED_NONE = 2'h0;
  localparam logic [1:0] OSMC_LED_RED = 2'h1;
  localparam logic [1:0] OSMC_LED_IR = 2'h2;
  localparam logic [1:0] OSMC_LAST_SLOT = 2'h3;

  // ****************************************
  // Sample rate, pulse width and data layout
  // ****************************************
  localparam int unsigned OSMC_RATE_SPS [8] = '{50, 100, 200, 400, 800, 1000, 1600, 3200};
  localparam logic [2:0] OSMC_OXI_MAX_RATE [4] = '{3'h6, 3'h5, 3'h4, 3'h3};
  localparam logic [2:0] OSMC_HR_MAX_RATE [4] = '{3'h7, 3'h6, 3'h6, 3'h5};
  localparam int OSMC_RES_BITS [4] = '{15, 16, 17, 18};
  localparam int OSMC_ADC_BITS = 18;
  localparam int OSMC_WORD_BITS = 24;
  localparam int OSMC_FIFO_DEPTH = 8;

endpackage

// file: hw/osmc_sample_fifo.sv
// Sample word FIFO with valid/ready on both sides and a synchronous flush.
// Assumes one clock; reset and flush empty it.
`timescale 1ns/1ps
`default_nettype none
module osmc_sample_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic flush_i,
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
  } osmc_fifo_s;

  osmc_fifo_s st;
  osmc_fifo_s next_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  assign in_ready_o = (st.count != (AW+1)'(DEPTH));
  assign out_valid_o = (st.count != '0);
  assign out_data_o = mem[st.rd_ptr];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_comb begin
    next_st = st;
    if (push) begin
      next_st.wr_ptr = (st.wr_ptr == AW'(DEPTH - 1)) ? '0 : st.wr_ptr + 1'b1;
    end
    if (pop) begin
      next_st.rd_ptr = (st.rd_ptr == AW'(DEPTH - 1)) ? '0 : st.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_st.count = st.count + 1'b1;
    end else if (pop && !push) begin
      next_st.count = st.count - 1'b1;
    end
    if (flush_i) begin
      next_st = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[st.wr_ptr] <= in_data_i;
    end
  end
endmodule
`default_nettype wire

// file: hw/osmc_measure_ctrl.sv
// Measurement control of an optical pulse and oximetry sensor: mode, soft reset, acquisition
// settings, LED drive, slot sequencing into the sample FIFO and die temperature readout.
// Assumes a byte-wide host register port and an analogue front end with start/done handshakes.
`timescale 1ns/1ps
`default_nettype none
module osmc_measure_ctrl #(
  parameter int unsigned CLK_HZ = osmc_pkg::OSMC_CLK_HZ
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic power_save_o,
  output logic irq_clear_o,
  output logic power_good_event_o,
  output logic [1:0] adc_full_scale_sel_o,
  output logic [1:0] pulse_width_sel_o,
  output logic [7:0] red_drive_level_o,
  output logic [7:0] ir_drive_level_o,
  output logic conv_start_o,
  output logic [1:0] conv_led_o,
  input wire logic conv_done_i,
  input wire logic [17:0] conv_data_i,
  output logic temp_start_o,
  input wire logic temp_done_i,
  input wire logic [7:0] temp_whole_i,
  input wire logic [3:0] temp_frac_i,
  output logic sample_valid_o,
  output logic [23:0] sample_data_o,
  input wire logic sample_ready_i
);
  import osmc_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_SCAN, SEQ_WAIT, SEQ_PUSH} osmc_seq_e;

  typedef struct packed {
    logic por_pending;
    logic pwr_good;
    logic power_save_request;
    logic [3:0] srst_cnt;
    logic [2:0] mode;
    logic [1:0] range;
    logic [2:0] rate;
    logic [1:0] pw;
    logic [7:0] red_amp;
    logic [7:0] ir_amp;
    logic [3:0][2:0] slots;
    logic [7:0] temp_whole;
    logic [3:0] temp_frac;
    logic temp_en;
    logic temp_start;
    logic [23:0] tick_cnt;
    osmc_seq_e seq;
    logic [1:0] slot_idx;
    logic conv_start;
    logic [1:0] conv_led;
    logic [23:0] push_data;
    logic [7:0] rdata;
  } osmc_state_s;

  localparam osmc_state_s POR_STATE = '{por_pending: 1'b1, seq: SEQ_IDLE, default: '0};

  osmc_state_s st;
  osmc_state_s next_st;
  logic fifo_in_ready;
  logic mode_valid;
  logic [2:0] cur_code;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [2:0] rate_limit(input logic [2:0] mode, input logic [1:0] pw);
    rate_limit = (mode == OSMC_MODE_HEART_RATE) ? OSMC_HR_MAX_RATE[pw] : OSMC_OXI_MAX_RATE[pw];
  endfunction

  function automatic logic [23:0] sample_period(input logic [2:0] rate);
    sample_period = 24'(CLK_HZ / OSMC_RATE_SPS[rate]);
  endfunction

  function automatic logic [2:0] slot_code(input osmc_state_s s, input logic [1:0] idx);
    slot_code = OSMC_SLOT_OFF;
    case (s.mode)
      OSMC_MODE_HEART_RATE: begin
        if (idx == 2'h0) slot_code = OSMC_SLOT_RED;
      end
      OSMC_MODE_OXIMETRY: begin
        if (idx == 2'h0) slot_code = OSMC_SLOT_RED;
        else if (idx == 2'h1) slot_code = OSMC_SLOT_IR;
      end
      OSMC_MODE_MULTI_LED: begin
        slot_code = s.slots[idx];
      end
      default: begin
        slot_code = OSMC_SLOT_OFF;
      end
    endcase
  endfunction

  function automatic logic [23:0] justify(input logic [17:0] data, input logic [1:0] pw);
    logic [17:0] mask;
    mask = 18'h3ffff << (OSMC_ADC_BITS - OSMC_RES_BITS[pw]);
    justify = {6'h00, data & mask};
  endfunction

  function automatic logic [7:0] read_mux(input osmc_state_s s, input logic [7:0] addr);
    read_mux = 8'h00;
    case (addr)
      OSMC_ADDR_OPERATING_MODE_CONTROL: begin
        read_mux[OSMC_MODE_POWER_SAVE_REQUEST_BIT] = s.power_save_request;
        read_mux[OSMC_MODE_RESET_BIT] = (s.srst_cnt != 4'h0);
        read_mux[OSMC_MODE_LSB +: 3] = s.mode;
      end
      OSMC_ADDR_ACQUISITION_CONFIG: begin
        read_mux[OSMC_CFG_RANGE_LSB +: 2] = s.range;
        read_mux[OSMC_CFG_RATE_LSB +: 3] = s.rate;
        read_mux[OSMC_CFG_PW_LSB +: 2] = s.pw;
      end
      OSMC_ADDR_RED_LED_AMPLITUDE: read_mux = s.red_amp;
      OSMC_ADDR_IR_LED_AMPLITUDE: read_mux = s.ir_amp;
      OSMC_ADDR_SLOT_SELECT_LOW: begin
        read_mux[OSMC_SLOT_LO_LSB +: 3] = s.slots[0];
        read_mux[OSMC_SLOT_HI_LSB +: 3] = s.slots[1];
      end
      OSMC_ADDR_SLOT_SELECT_HIGH: begin
        read_mux[OSMC_SLOT_LO_LSB +: 3] = s.slots[2];
        read_mux[OSMC_SLOT_HI_LSB +: 3] = s.slots[3];
      end
      OSMC_ADDR_DIE_TEMP_WHOLE: read_mux = s.temp_whole;
      OSMC_ADDR_DIE_TEMP_FRACTION: read_mux[3:0] = s.temp_frac;
      OSMC_ADDR_DIE_TEMP_TRIGGER: read_mux[OSMC_TEMP_EN_BIT] = s.temp_en;
      default: read_mux = 8'h00;
    endcase
  endfunction

  assign mode_valid = (st.mode == OSMC_MODE_HEART_RATE) || (st.mode == OSMC_MODE_OXIMETRY) ||
                      (st.mode == OSMC_MODE_MULTI_LED);
  assign cur_code = slot_code(st, st.slot_idx);

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_st = st;
    next_st.pwr_good = st.por_pending;
    next_st.por_pending = 1'b0;
    next_st.conv_start = 1'b0;
    next_st.temp_start = 1'b0;

    // Registered read data, valid in all states including power save
    if (reg_rd_i) begin
      next_st.rdata = read_mux(st, reg_addr_i);
    end

    // Slot sequencer
    if (st.power_save_request || !mode_valid) begin
      next_st.tick_cnt = '0;
      next_st.seq = SEQ_IDLE;
    end else begin
      if (st.tick_cnt >= sample_period(st.rate) - 24'h1) begin
        next_st.tick_cnt = '0;
        if (st.seq == SEQ_IDLE) begin
          next_st.seq = SEQ_SCAN;
          next_st.slot_idx = 2'h0;
        end
      end else begin
        next_st.tick_cnt = st.tick_cnt + 24'h1;
      end
      case (st.seq)
        SEQ_IDLE: begin
        end
        SEQ_SCAN: begin
          if (cur_code != OSMC_SLOT_OFF && cur_code <= OSMC_SLOT_LAST_ACTIVE) begin
            next_st.conv_start = 1'b1;
            next_st.conv_led = (cur_code == OSMC_SLOT_RED) ? OSMC_LED_RED :
                               (cur_code == OSMC_SLOT_IR) ? OSMC_LED_IR : OSMC_LED_NONE;
            next_st.seq = SEQ_WAIT;
          end else if (st.slot_idx == OSMC_LAST_SLOT) begin
            next_st.seq = SEQ_IDLE;
          end else begin
            next_st.slot_idx = st.slot_idx + 2'h1;
          end
        end
        SEQ_WAIT: begin
          if (conv_done_i) begin
            next_st.push_data = justify(conv_data_i, st.pw);
            next_st.seq = SEQ_PUSH;
          end
        end
        SEQ_PUSH: begin
          if (fifo_in_ready) begin
            if (st.slot_idx == OSMC_LAST_SLOT) begin
              next_st.seq = SEQ_IDLE;
            end else begin
              next_st.slot_idx = st.slot_idx + 2'h1;
              next_st.seq = SEQ_SCAN;
            end
          end
        end
        default: begin
          next_st.seq = SEQ_IDLE;
        end
      endcase
    end

    // Temperature conversion completion, both results taken on one edge
    if (st.temp_en && temp_done_i) begin
      next_st.temp_whole = temp_whole_i;
      next_st.temp_frac = temp_frac_i;
      next_st.temp_en = 1'b0;
    end

    // Host writes, ignored while a soft reset is running
    if (reg_wr_i && st.srst_cnt == 4'h0) begin
      case (reg_addr_i)
        OSMC_ADDR_OPERATING_MODE_CONTROL: begin
          if (reg_wdata_i[OSMC_MODE_RESET_BIT]) begin
            next_st.srst_cnt = OSMC_SOFT_RESET_CYCLES;
          end else begin
            next_st.power_save_request = reg_wdata_i[OSMC_MODE_POWER_SAVE_REQUEST_BIT];
            next_st.mode = reg_wdata_i[OSMC_MODE_LSB +: 3];
          end
        end
        OSMC_ADDR_ACQUISITION_CONFIG: begin
          next_st.range = reg_wdata_i[OSMC_CFG_RANGE_LSB +: 2];
          next_st.pw = reg_wdata_i[OSMC_CFG_PW_LSB +: 2];
          if (reg_wdata_i[OSMC_CFG_RATE_LSB +: 3] > rate_limit(st.mode, reg_wdata_i[OSMC_CFG_PW_LSB +: 2])) begin
            next_st.rate = rate_limit(st.mode, reg_wdata_i[OSMC_CFG_PW_LSB +: 2]);
          end else begin
            next_st.rate = reg_wdata_i[OSMC_CFG_RATE_LSB +: 3];
          end
        end
        OSMC_ADDR_RED_LED_AMPLITUDE: next_st.red_amp = reg_wdata_i;
        OSMC_ADDR_IR_LED_AMPLITUDE: next_st.ir_amp = reg_wdata_i;
        OSMC_ADDR_SLOT_SELECT_LOW: begin
          next_st.slots[0] = reg_wdata_i[OSMC_SLOT_LO_LSB +: 3];
          next_st.slots[1] = reg_wdata_i[OSMC_SLOT_HI_LSB +: 3];
        end
        OSMC_ADDR_SLOT_SELECT_HIGH: begin
          next_st.slots[2] = reg_wdata_i[OSMC_SLOT_LO_LSB +: 3];
          next_st.slots[3] = reg_wdata_i[OSMC_SLOT_HI_LSB +: 3];
        end
        OSMC_ADDR_DIE_TEMP_TRIGGER: begin
          if (reg_wdata_i[OSMC_TEMP_EN_BIT] && !st.temp_en) begin
            next_st.temp_en = 1'b1;
            next_st.temp_start = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end

    // Soft reset sequence; power-good stays quiet
    if (st.srst_cnt != 4'h0) begin
      next_st.srst_cnt = st.srst_cnt - 4'h1;
      if (st.srst_cnt == 4'h1) begin
        next_st = POR_STATE;
        next_st.por_pending = 1'b0;
        next_st.rdata = reg_rd_i ? read_mux(st, reg_addr_i) : st.rdata;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st <= POR_STATE;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************
  // Sample FIFO
  // ****************************************
  osmc_sample_fifo #(
    .WIDTH(OSMC_WORD_BITS),
    .DEPTH(OSMC_FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .flush_i(st.srst_cnt == 4'h1),
    .in_valid_i(st.seq == SEQ_PUSH && !st.power_save_request && mode_valid),
    .in_data_i(st.push_data),
    .in_ready_o(fifo_in_ready),
    .out_valid_o(sample_valid_o),
    .out_data_o(sample_data_o),
    .out_ready_i(sample_ready_i)
  );

  // ****************************************
  // Outputs
  // ****************************************
  assign reg_rdata_o = st.rdata;
  assign power_save_o = st.power_save_request;
  assign irq_clear_o = st.power_save_request;
  assign power_good_event_o = st.pwr_good;
  assign adc_full_scale_sel_o = st.range;
  assign pulse_width_sel_o = st.pw;
  assign red_drive_level_o = st.red_amp;
  assign ir_drive_level_o = st.ir_amp;
  assign conv_start_o = st.conv_start;
  assign conv_led_o = st.conv_led;
  assign temp_start_o = st.temp_start;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  property p_shutdown_write;
    reg_wr_i && st.srst_cnt == 4'h0 && reg_addr_i == OSMC_ADDR_OPERATING_MODE_CONTROL &&
      !reg_wdata_i[OSMC_MODE_RESET_BIT] |=> power_save_o == $past(reg_wdata_i[OSMC_MODE_POWER_SAVE_REQUEST_BIT]);
  endproperty
  a_shutdown_write: assert property (p_shutdown_write) else $error("shutdown bit not applied");

  property p_irq_clear;
    power_save_o |-> irq_clear_o;
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("interrupts not cleared in power save");

  property p_soft_reset;
    reg_wr_i && st.srst_cnt == 4'h0 && reg_addr_i == OSMC_ADDR_OPERATING_MODE_CONTROL &&
      reg_wdata_i[OSMC_MODE_RESET_BIT] |=> (st.srst_cnt != 4'h0)[*4] ##1
      (st.srst_cnt == 4'h0 && red_drive_level_o == 8'h00 && st.mode == 3'h0 && !power_save_o);
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset sequence wrong");

  property p_no_power_good;
    st.srst_cnt != 4'h0 |=> !power_good_event_o[*2];
  endproperty
  a_no_power_good: assert property (p_no_power_good) else $error("power-good during soft reset");

  property p_rate_clamp;
    reg_wr_i && st.srst_cnt == 4'h0 && reg_addr_i == OSMC_ADDR_ACQUISITION_CONFIG &&
      st.mode == OSMC_MODE_OXIMETRY && reg_wdata_i[1:0] == 2'h3 && reg_wdata_i[4:2] > 3'h3
      |=> st.rate == 3'h3;
  endproperty
  a_rate_clamp: assert property (p_rate_clamp) else $error("sample rate not clamped");

  property p_mode_keeps_config;
    reg_wr_i && st.srst_cnt == 4'h0 && reg_addr_i == OSMC_ADDR_OPERATING_MODE_CONTROL &&
      !reg_wdata_i[OSMC_MODE_RESET_BIT] |=> $stable(st.rate) && $stable(st.pw) && $stable(red_drive_level_o);
  endproperty
  a_mode_keeps_config: assert property (p_mode_keeps_config) else $error("mode write changed config");

  property p_left_justified;
    st.seq == SEQ_PUSH |-> st.push_data[23:18] == 6'h00 &&
      (st.pw != 2'h0 || st.push_data[2:0] == 3'h0);
  endproperty
  a_left_justified: assert property (p_left_justified) else $error("result not left-justified");

  property p_temp_done;
    st.temp_en && temp_done_i |=> !st.temp_en && st.temp_whole == $past(temp_whole_i) &&
      st.temp_frac == $past(temp_frac_i);
  endproperty
  a_temp_done: assert property (p_temp_done) else $error("temperature result not captured");

  property p_temp_start;
    reg_wr_i && st.srst_cnt == 4'h0 && reg_addr_i == OSMC_ADDR_DIE_TEMP_TRIGGER &&
      reg_wdata_i[0] && !st.temp_en |=> temp_start_o ##1 !temp_start_o;
  endproperty
  a_temp_start: assert property (p_temp_start) else $error("temperature start not single");

  property p_reserved_zero;
    reg_rd_i && reg_addr_i == OSMC_ADDR_OPERATING_MODE_CONTROL |=> reg_rdata_o[5:3] == 3'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits read nonzero");
endmodule
`default_nettype wire

// file: test/osmc_front_end_model.sv
// Behavioural analogue front end: answers conversion and temperature starts.
// Assumes start pulses come from the measurement control block.
`timescale 1ns/1ps
`default_nettype none
module osmc_front_end_model (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic start_i,
  input wire logic [1:0] led_i,
  input wire logic tstart_i,
  output logic done_o,
  output logic [17:0] data_o,
  output logic tdone_o,
  output logic [7:0] whole_o,
  output logic [3:0] frac_o
);
  import osmc_pkg::*;
  // ****************************************
  // Delayed answers
  // ****************************************
  logic [3:0] csr;
  logic [5:0] tsr;
  logic [17:0] val;
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      csr <= '0;
      tsr <= '0;
      val <= '0;
    end else begin
      csr <= {csr[2:0], start_i};
      tsr <= {tsr[4:0], tstart_i};
      if (start_i) begin
        val <= (led_i == OSMC_LED_RED) ? 18'h15555 : (led_i == OSMC_LED_IR) ? 18'h2aaab : 18'h0aaaa;
      end
    end
  end
  // Outside done the lines carry the inverse, never a stale copy
  assign done_o = csr[3];
  assign data_o = done_o ? val : ~val;
  assign tdone_o = tsr[5];
  assign whole_o = tdone_o ? 8'hf6 : 8'h09;
  assign frac_o = tdone_o ? 4'h9 : 4'h6;
endmodule
`default_nettype wire

// file: test/test_osmc_measure_ctrl.sv
// Self-checking testbench of the measurement control block.
// Assumes the front-end model answers every start.
`timescale 1ns/1ps
`default_nettype none
module test_osmc_measure_ctrl;
  import osmc_pkg::*;
  logic clk_i = 0, reset_i = 1, wr = 0, rd = 0, rdy = 0;
  logic [7:0] addr = 0, wd = 0, rdata, tw, rl, il, q;
  logic [23:0] sd;
  logic [17:0] cd;
  logic [3:0] tf;
  logic ps, ic, pg, cs, cdn, ts, tdn, sv;
  logic [1:0] fs, pw, cl;
  int fail_count = 0, tests_run = 0, pg_n = 0, cyc = 0;
  osmc_measure_ctrl #(.CLK_HZ(20000)) DUT (.clk_i(clk_i), .reset_i(reset_i), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wd), .reg_rdata_o(rdata), .power_save_o(ps),
    .irq_clear_o(ic), .power_good_event_o(pg), .adc_full_scale_sel_o(fs), .pulse_width_sel_o(pw),
    .red_drive_level_o(rl), .ir_drive_level_o(il), .conv_start_o(cs), .conv_led_o(cl),
    .conv_done_i(cdn), .conv_data_i(cd), .temp_start_o(ts), .temp_done_i(tdn), .temp_whole_i(tw),
    .temp_frac_i(tf), .sample_valid_o(sv), .sample_data_o(sd), .sample_ready_i(rdy));
  osmc_front_end_model fe (.clk_i(clk_i), .reset_i(reset_i), .start_i(cs), .led_i(cl),
    .tstart_i(ts), .done_o(cdn), .data_o(cd), .tdone_o(tdn), .whole_o(tw), .frac_o(tf));
  // ****************************************
  // Clock, watchdog and helpers
  // ****************************************
  initial forever #25 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc++;
    if (pg === 1'b1) pg_n++;
    if (cyc == 20000) begin
      fail_count++;
      give_verdict;
    end
  end
  task give_verdict;
    if (fail_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input logic [23:0] seen, input logic [23:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task wrr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    wr = 1;
    addr = a;
    wd = d;
    @(negedge clk_i);
    wr = 0;
  endtask
  task rdr(input logic [7:0] a);
    @(negedge clk_i);
    rd = 1;
    addr = a;
    @(negedge clk_i);
    rd = 0;
    q = rdata;
  endtask
  task rdc(input logic [7:0] a, input logic [7:0] e);
    rdr(a);
    chk({16'h0, q}, {16'h0, e});
  endtask
  task get_word(input logic [23:0] e);
    int n;
    n = 0;
    @(negedge clk_i);
    while (sv !== 1'b1 && n < 2000) begin
      @(negedge clk_i);
      n++;
    end
    chk(sv, 1'b1);
    chk(sd, e);
    rdy = 1;
    @(negedge clk_i);
    rdy = 0;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task t_reset;
    rdc(8'h09, 8'h00);
    rdc(8'h0a, 8'h00);
    rdc(8'h1f, 8'h00);
    rdc(8'h05, 8'h00);
    chk(pg_n, 1);
  endtask
  task t_config;
    wrr(8'h09, 8'h3b);
    rdc(8'h09, 8'h03);
    wrr(8'h0a, 8'hff);
    rdc(8'h0a, 8'h6f);
    chk(fs, 2'h3);
    chk(pw, 2'h3);
    wrr(8'h09, 8'h02);
    rdc(8'h0a, 8'h6f);
    wrr(8'h0a, 8'hff);
    rdc(8'h0a, 8'h77);
    wrr(8'h11, 8'hff);
    rdc(8'h11, 8'h77);
    wrr(8'h0c, 8'ha5);
    wrr(8'h0d, 8'h5a);
    chk(rl, 8'ha5);
    chk(il, 8'h5a);
  endtask
  task t_power_save_request;
    wrr(8'h09, 8'h83);
    chk(ps, 1'b1);
    chk(ic, 1'b1);
    wrr(8'h0c, 8'h3c);
    rdc(8'h0c, 8'h3c);
    rdc(8'h09, 8'h83);
    wrr(8'h09, 8'h03);
    chk(ps, 1'b0);
    chk(ic, 1'b0);
  endtask
  task t_soft;
    int n;
    wrr(8'h09, 8'h40);
    rdc(8'h09, 8'h43);
    n = 0;
    while (q !== 8'h00 && n < 10) begin
      rdr(8'h09);
      n++;
    end
    chk(q, 8'h00);
    rdc(8'h0c, 8'h00);
    rdc(8'h0a, 8'h00);
    chk(sv, 1'b0);
    chk(pg_n, 1);
  endtask
  task t_oxi;
    wrr(8'h0a, 8'h0c);
    wrr(8'h09, 8'h03);
    repeat (700) @(negedge clk_i);
    chk(sv, 1'b1);
    for (int i = 0; i < 10; i++) get_word(i[0] ? 24'h02aaa8 : 24'h015550);
  endtask
  task t_multi;
    wrr(8'h09, 8'h40);
    repeat (8) @(negedge clk_i);
    wrr(8'h0a, 8'h0c);
    wrr(8'h11, 8'h12);
    wrr(8'h12, 8'h03);
    wrr(8'h09, 8'h07);
    get_word(24'h02aaa8);
    get_word(24'h015550);
    get_word(24'h00aaa8);
  endtask
  task t_temp;
    int n;
    wrr(8'h21, 8'h01);
    rdc(8'h21, 8'h01);
    n = 0;
    while (q !== 8'h00 && n < 20) begin
      rdr(8'h21);
      n++;
    end
    chk(q, 8'h00);
    rdc(8'h1f, 8'hf6);
    rdc(8'h20, 8'h09);
  endtask
  initial begin
    repeat (12) @(negedge clk_i);
    reset_i = 0;
    t_reset;
    t_config;
    t_power_save_request;
    t_soft;
    t_oxi;
    t_multi;
    t_temp;
    give_verdict;
  end
endmodule
`default_nettype wire
